// File: logic/ppr_bus_side.sv
// initiator handshake, parity, bus reset and hold exchange on the parallel bus
// Function
// [RULE1] phase ends when both readies sampled low
// [RULE2] write: initiator-ready only with valid data driven
// [RULE3] read: initiator-ready means ready to capture data
// [RULE4] drive initiator-ready only as master
// [RULE5] even parity over address/data and command lines
// [RULE6] parity always spans all 36 bits
// [RULE7] parity follows address/data enables one clock later
// [RULE8] parity on own address, own write, target read
// [RULE9] bus reset asserted at power-up and hard reset
// [RULE10] release at least 1 ms after power good
// [RULE11] software hard reset held at least 1 ms
// [RULE12] bus reset edges independent of the clock; here only the fall on device reset is, the timer's edges follow clock_i
// [RULE13] bus reset low in reset, high afterwards
// [RULE14] request the bus by pulling hold low
// [RULE15] arbiter keeps grant until hold is released
// [RULE16] passive release pulses hold high one clock
// [RULE17] hold floats in reset, driven high after
// [RULE18] arbiter grants by pulling grant low
// [RULE19] drive bus only while grant is held
module ppr_bus_side #(
  parameter int RESET_HOLD_CYCLES = ppr_pkg::RESET_HOLD_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  // power and reset
  input wire logic power_good_in_i,
  input wire logic hard_reset_start_i,
  output logic bus_reset_out_n_o,
  // arbiter exchange
  output logic bus_hold_request_n_o,
  output logic bus_hold_request_n_oe_o,
  input wire logic bus_hold_grant_n_i,
  input wire logic passive_release_i,
  // user request side
  input wire logic req_valid_i,
  input wire ppr_pkg::ppr_req_type req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [ppr_pkg::AD_W-1:0] rd_data_o,
  // target side hooks
  input wire logic tgt_active_i,
  input wire logic tgt_read_drive_i,
  input wire logic [ppr_pkg::AD_W-1:0] tgt_rd_data_i,
  output logic tgt_done_o,
  // bus pins
  output ppr_pkg::ppr_adbus_type adbus_o,
  input wire logic [ppr_pkg::AD_W-1:0] ad_i,
  input wire logic [ppr_pkg::CBE_W-1:0] cbe_n_i,
  output logic frame_n_o,
  output logic frame_n_oe_o,
  output logic irdy_n_o,
  output logic irdy_n_oe_o,
  input wire logic irdy_n_i,
  input wire logic trdy_n_i,
  output logic par_o,
  output logic par_oe_o
);

  ppr_pkg::ppr_state_type state_r;
  ppr_pkg::ppr_state_type state_nxt;
  ppr_pkg::ppr_req_type req_r;
  ppr_pkg::ppr_adbus_type adbus_r;
  ppr_pkg::ppr_adbus_type adbus_nxt;
  logic pg_meta_r;
  logic pg_sync_r;
  logic reset_hold;
  logic grant;
  logic take;
  logic phase_done;
  logic hold_req_n_r;
  logic hold_oe_r;
  logic release_r;
  logic frame_n_r;
  logic frame_oe_r;
  logic irdy_n_r;
  logic irdy_oe_r;
  logic irdy_n_nxt;
  logic irdy_oe_nxt;
  logic frame_n_nxt;
  logic frame_oe_nxt;
  logic par_r;
  logic par_oe_r;
  logic done_r;
  logic [ppr_pkg::AD_W-1:0] rd_data_r;
  logic [ppr_pkg::CBE_W-1:0] cbe_on_bus;

  // power good arrives from outside the clock domain
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pg_meta_r <= 1'b0;
      pg_sync_r <= 1'b0;
    end
    else
    begin
      pg_meta_r <= power_good_in_i;
      pg_sync_r <= pg_meta_r;
    end
  end

  ppr_reset_timer #(
    .HOLD_CYCLES(RESET_HOLD_CYCLES),
    .CNT_W(ppr_pkg::RESET_CNT_W)
  ) u_reset_timer (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .power_good_i(pg_sync_r),
    .hard_reset_start_i(hard_reset_start_i),
    .hold_active_o(reset_hold)
  );

  // device reset pulls the pin low at once, with no clock edge needed
  assign bus_reset_out_n_o = nrst_i & ~reset_hold; // [RULE12] [RULE13]

  assign grant = ~bus_hold_grant_n_i; // [RULE18]
  assign phase_done = ~irdy_n_i & ~trdy_n_i; // [RULE1]
  assign tgt_done_o = tgt_active_i & phase_done; // [RULE1] [RULE4]

  // a new transaction starts only with the grant held and no release pulse
  assign take = req_valid_i & req_ready_o;
  assign req_ready_o = (state_r == ppr_pkg::PPR_IDLE) & grant & ~hold_req_n_r & ~release_r
    & ~reset_hold & ~tgt_active_i; // [RULE19]

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ppr_pkg::PPR_IDLE:
      begin
        if (take)
        begin
          state_nxt = ppr_pkg::PPR_ADDR;
        end
      end
      ppr_pkg::PPR_ADDR:
      begin
        state_nxt = ppr_pkg::PPR_DATA;
      end
      ppr_pkg::PPR_DATA:
      begin
        if (phase_done)
        begin
          state_nxt = ppr_pkg::PPR_TURN; // [RULE1]
        end
      end
      ppr_pkg::PPR_TURN:
      begin
        state_nxt = ppr_pkg::PPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= ppr_pkg::PPR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      req_r <= '0;
    end
    else if (take)
    begin
      req_r <= req_i;
    end
  end

  // pin values for the coming cycle, derived from the next state
  always_comb
  begin
    adbus_nxt.ad = adbus_r.ad;
    adbus_nxt.ad_oe = 1'b0;
    adbus_nxt.cbe_n = ppr_pkg::CBE_RESET;
    adbus_nxt.cbe_oe = 1'b0;
    frame_n_nxt = 1'b1;
    frame_oe_nxt = 1'b0;
    irdy_n_nxt = 1'b1;
    irdy_oe_nxt = 1'b0;
    unique case (state_nxt)
      ppr_pkg::PPR_IDLE:
      begin
        if (tgt_read_drive_i)
        begin
          adbus_nxt.ad = tgt_rd_data_i;
          adbus_nxt.ad_oe = 1'b1;
        end
      end
      ppr_pkg::PPR_ADDR:
      begin
        adbus_nxt.ad = {req_i.addr[ppr_pkg::AD_W-1:2], 2'b00};
        adbus_nxt.ad_oe = 1'b1;
        adbus_nxt.cbe_n = req_i.cmd;
        adbus_nxt.cbe_oe = 1'b1;
        frame_n_nxt = 1'b0;
        frame_oe_nxt = 1'b1;
        irdy_oe_nxt = 1'b1; // [RULE4]
      end
      ppr_pkg::PPR_DATA:
      begin
        // single data phase: frame rises with initiator-ready falling
        adbus_nxt.ad = req_r.write ? req_r.data : adbus_r.ad;
        adbus_nxt.ad_oe = req_r.write; // [RULE2]
        adbus_nxt.cbe_n = req_r.be;
        adbus_nxt.cbe_oe = 1'b1;
        frame_oe_nxt = 1'b1;
        irdy_n_nxt = 1'b0; // [RULE2] [RULE3]
        irdy_oe_nxt = 1'b1; // [RULE4]
      end
      ppr_pkg::PPR_TURN:
      begin
        // drive initiator-ready high one clock before floating it
        irdy_oe_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      adbus_r.ad <= ppr_pkg::AD_RESET;
      adbus_r.ad_oe <= 1'b0;
      adbus_r.cbe_n <= ppr_pkg::CBE_RESET;
      adbus_r.cbe_oe <= 1'b0;
      frame_n_r <= 1'b1;
      frame_oe_r <= 1'b0;
      irdy_n_r <= 1'b1;
      irdy_oe_r <= 1'b0;
    end
    else
    begin
      adbus_r <= adbus_nxt; // [RULE19]
      frame_n_r <= frame_n_nxt;
      frame_oe_r <= frame_oe_nxt;
      irdy_n_r <= irdy_n_nxt;
      irdy_oe_r <= irdy_oe_nxt; // [RULE4]
    end
  end

  // read data captured on the clock that completes the phase
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_data_r <= ppr_pkg::AD_RESET;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_r == ppr_pkg::PPR_DATA) & phase_done;
      if ((state_r == ppr_pkg::PPR_DATA) & phase_done & ~req_r.write)
      begin
        rd_data_r <= ad_i; // [RULE3]
      end
    end
  end

  // as target of a read the command lines belong to the other initiator
  assign cbe_on_bus = adbus_r.cbe_oe ? adbus_r.cbe_n : cbe_n_i;

  // parity lags the lines it covers by one clock, enable included
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      par_r <= 1'b0;
      par_oe_r <= 1'b0;
    end
    else
    begin
      par_r <= ^{adbus_r.ad, cbe_on_bus}; // [RULE5] [RULE6]
      par_oe_r <= adbus_r.ad_oe; // [RULE7] [RULE8]
    end
  end

  // hold stays low from request until the transaction is over
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hold_req_n_r <= 1'b1;
      hold_oe_r <= 1'b0;
      release_r <= 1'b0;
    end
    else
    begin
      hold_oe_r <= 1'b1; // [RULE17]
      release_r <= passive_release_i & ~hold_req_n_r & ~release_r
        & (state_r == ppr_pkg::PPR_IDLE) & ~take;
      if (reset_hold)
      begin
        hold_req_n_r <= 1'b1;
      end
      else if (passive_release_i & ~hold_req_n_r & ~release_r
        & (state_r == ppr_pkg::PPR_IDLE) & ~take)
      begin
        hold_req_n_r <= 1'b1; // [RULE16]
      end
      else if (req_valid_i | (state_nxt != ppr_pkg::PPR_IDLE))
      begin
        hold_req_n_r <= 1'b0; // [RULE14] [RULE15]
      end
      else
      begin
        hold_req_n_r <= 1'b1;
      end
    end
  end

  assign bus_hold_request_n_o = hold_req_n_r;
  assign bus_hold_request_n_oe_o = hold_oe_r; // [RULE17]
  assign adbus_o = adbus_r;
  assign frame_n_o = frame_n_r;
  assign frame_n_oe_o = frame_oe_r;
  assign irdy_n_o = irdy_n_r;
  assign irdy_n_oe_o = irdy_oe_r;
  assign par_o = par_r;
  assign par_oe_o = par_oe_r;
  assign done_o = done_r;
  assign rd_data_o = rd_data_r;

endmodule

// File: logic/ppr_pkg.sv
// shared constants and carrier types for the bus-side signalling block
package ppr_pkg;

  // bus clock rate and reset hold time
  localparam int CLOCK_KHZ = 40000;
  localparam int RESET_HOLD_TIME_US = 1000;
  // least time, so round up to whole cycles
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_TIME_US * CLOCK_KHZ + 999) / 1000;
  localparam int RESET_CNT_W = 17;

  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int PARITY_SPAN = AD_W + CBE_W;

  // values after reset
  localparam logic [AD_W-1:0] AD_RESET = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_RESET = 4'hf;

  // master sequence, gray coded along idle-addr-data-turn
  typedef enum logic [1:0] {
    PPR_IDLE = 2'b00,
    PPR_ADDR = 2'b01,
    PPR_DATA = 2'b11,
    PPR_TURN = 2'b10
  } ppr_state_type;

  typedef struct packed {
    logic write;
    logic [AD_W-1:0] addr;
    logic [CBE_W-1:0] cmd;
    logic [AD_W-1:0] data;
    logic [CBE_W-1:0] be;
  } ppr_req_type;

  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic [CBE_W-1:0] cbe_n;
    logic cbe_oe;
  } ppr_adbus_type;

endpackage

// File: logic/ppr_reset_timer.sv
// bus reset hold timer: holds reset from power-up or a software hard reset
module ppr_reset_timer #(
  parameter int HOLD_CYCLES = ppr_pkg::RESET_HOLD_CYCLES,
  parameter int CNT_W = ppr_pkg::RESET_CNT_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic power_good_i,
  input wire logic hard_reset_start_i,
  output logic hold_active_o
);

  logic [CNT_W-1:0] count_r;
  logic active_r;

  localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(HOLD_CYCLES - 1);

  // power-up state is asserted; release only after a full hold with power good
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      active_r <= 1'b1;
      count_r <= '0;
    end
    else if (!power_good_i || hard_reset_start_i)
    begin
      active_r <= 1'b1; // [RULE9]
      count_r <= '0;
    end
    else if (active_r)
    begin
      count_r <= count_r + CNT_W'(1);
      if (count_r == LAST_COUNT)
      begin
        active_r <= 1'b0; // [RULE10] [RULE11]
      end
    end
  end

  assign hold_active_o = active_r;

endmodule

// File: test/ppr_bus_side_sva.sv
// assertions on the ports of the bus-side signalling block
module ppr_bus_side_sva #(
  parameter int RESET_HOLD_CYCLES = 16
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic bus_reset_out_n_o,
  input wire logic bus_hold_request_n_o,
  input wire logic bus_hold_request_n_oe_o,
  input wire logic bus_hold_grant_n_i,
  input wire logic req_valid_i,
  input wire logic done_o,
  input wire ppr_pkg::ppr_adbus_type adbus_o,
  input wire logic [ppr_pkg::CBE_W-1:0] cbe_n_i,
  input wire logic frame_n_o,
  input wire logic frame_n_oe_o,
  input wire logic irdy_n_o,
  input wire logic irdy_n_oe_o,
  input wire logic trdy_n_i,
  input wire logic par_o,
  input wire logic par_oe_o
);
  logic [3:0] cbe_bus;
  int low_cnt;
  assign cbe_bus = adbus_o.cbe_oe ? adbus_o.cbe_n : cbe_n_i;
  // counts edges with the bus reset low, so a short pulse shows
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      low_cnt <= 0;
    else if (bus_reset_out_n_o)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  par_lag_a: assert property (par_oe_o == $past(adbus_o.ad_oe))
    else $error("parity enable not one clock late");
  par_even_a: assert property (par_oe_o |->
    (par_o == ^{$past(adbus_o.ad), $past(cbe_bus)}))
    else $error("parity not even");
  phase_end_a: assert property (!irdy_n_o && irdy_n_oe_o && !trdy_n_i |=> done_o)
    else $error("phase did not end");
  irdy_start_a: assert property ($rose(irdy_n_oe_o) |->
    frame_n_oe_o && !frame_n_o && irdy_n_o)
    else $error("ready driven outside a started cycle");
  irdy_data_a: assert property ($fell(irdy_n_o) && irdy_n_oe_o |->
    !$past(frame_n_o) && adbus_o.cbe_oe)
    else $error("ready not in data phase");
  grant_use_a: assert property ($rose(frame_n_oe_o) |-> !$past(bus_hold_grant_n_i))
    else $error("cycle started without grant");
  passive_a: assert property ($rose(bus_hold_request_n_o) && req_valid_i |=>
    !bus_hold_request_n_o)
    else $error("passive release longer than a clock");
  in_reset_a: assert property (disable iff (1'b0) !nrst_i |->
    !bus_reset_out_n_o && !bus_hold_request_n_oe_o)
    else $error("pins wrong in reset");
  reset_len_a: assert property ($rose(bus_reset_out_n_o) |->
    low_cnt >= RESET_HOLD_CYCLES)
    else $error("bus reset too short");
endmodule

bind ppr_bus_side ppr_bus_side_sva #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) chk (.clock_i,
  .nrst_i, .bus_reset_out_n_o, .bus_hold_request_n_o, .bus_hold_request_n_oe_o,
  .bus_hold_grant_n_i, .req_valid_i, .done_o, .adbus_o, .cbe_n_i, .frame_n_o, .frame_n_oe_o,
  .irdy_n_o, .irdy_n_oe_o, .trdy_n_i, .par_o, .par_oe_o);

// File: test/ppr_agent_model.sv
// far side: arbiter plus a target with set wait states
module ppr_agent_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic hold_n_i,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic drv_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] wait_i,
  input wire logic [31:0] rd_i,
  output logic grant_n_o,
  output logic trdy_n_o,
  output logic [31:0] ad_o,
  output logic [31:0] addr_o,
  output logic [31:0] wdat_o
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [31:0] last_r;
  assign trdy_n_o = !(busy_r && cnt_r == wait_i);
  // released lines flip each cycle so stale data cannot pass
  assign ad_o = (busy_r && !drv_i) ? rd_i : ~last_r;
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      grant_n_o <= 1'h1;
      busy_r <= 1'h0;
      cnt_r <= 4'h0;
      last_r <= 32'h0;
    end
    else
    begin
      grant_n_o <= hold_n_i;
      last_r <= ad_o;
      if (!frame_n_i)
      begin
        busy_r <= 1'h1;
        cnt_r <= 4'h0;
        addr_o <= ad_i;
      end
      // the phase ends only with both readies low; trdy holds meanwhile
      else if (busy_r && !trdy_n_o && !irdy_n_i)
      begin
        busy_r <= 1'h0;
        wdat_o <= ad_i;
      end
      else if (busy_r && cnt_r != wait_i)
        cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// File: test/test_pci_parity_reset_hold.sv
// self-checking bench for the bus-side signalling block
module test_pci_parity_reset_hold;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 16;
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic pg = 1'h0, hrst = 1'h0, prel = 1'h0, rv = 1'h0, tga = 1'h0, tgd = 1'h0;
  logic [31:0] tgdat = 32'h0, rdv = 32'h0, mad, rdo, addr_q, wdat_q, ad_w;
  logic [3:0] wt = 4'h0, cbe_w;
  ppr_pkg::ppr_req_type rq = '0;
  ppr_pkg::ppr_adbus_type ab;
  logic rst_n, hn, hoe, gn, rdy, dn, tdn, fn, foe, irn, iroe, trn, par, poe, fr_w, ir_w, hd_w;
  int err_count = 0;
  int cmp_count = 0;
  // pulled-up control lines read high when nobody drives them; ad reads the far side model
  assign ad_w = ab.ad_oe ? ab.ad : mad;
  assign cbe_w = ab.cbe_oe ? ab.cbe_n : 4'hf;
  assign fr_w = foe ? fn : 1'h1;
  assign ir_w = iroe ? irn : 1'h1;
  assign hd_w = hoe ? hn : 1'h1;
  always #12.5 clock_i = ~clock_i;
  ppr_bus_side #(.RESET_HOLD_CYCLES(H)) DUT (.clock_i, .nrst_i, .power_good_in_i(pg),
    .hard_reset_start_i(hrst), .bus_reset_out_n_o(rst_n), .bus_hold_request_n_o(hn),
    .bus_hold_request_n_oe_o(hoe), .bus_hold_grant_n_i(gn), .passive_release_i(prel),
    .req_valid_i(rv), .req_i(rq), .req_ready_o(rdy), .done_o(dn), .rd_data_o(rdo),
    .tgt_active_i(tga), .tgt_read_drive_i(tgd), .tgt_rd_data_i(tgdat), .tgt_done_o(tdn),
    .adbus_o(ab), .ad_i(ad_w), .cbe_n_i(cbe_w), .frame_n_o(fn), .frame_n_oe_o(foe),
    .irdy_n_o(irn), .irdy_n_oe_o(iroe), .irdy_n_i(ir_w), .trdy_n_i(trn), .par_o(par),
    .par_oe_o(poe));
  ppr_agent_model far (.clock_i, .nrst_i, .hold_n_i(hd_w), .frame_n_i(fr_w), .irdy_n_i(ir_w),
    .drv_i(ab.ad_oe), .ad_i(ad_w), .wait_i(wt), .rd_i(rdv), .grant_n_o(gn), .trdy_n_o(trn),
    .ad_o(mad), .addr_o(addr_q), .wdat_o(wdat_q));
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic w, input logic [31:0] a, input logic [31:0] d);
    rq = '{w, a, w ? 4'h7 : 4'h6, d, 4'h0};
    rv = 1'h1;
  endtask
  // waits for the take edge, then for done, both bounded
  task automatic fin;
    int n;
    n = 0;
    while (rdy !== 1'h1 && n < 100)
    begin
      tick(1);
      n++;
    end
    tick(1);
    rv = 1'h0;
    while (dn !== 1'h1 && n < 100)
    begin
      tick(1);
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      summarize();
    end
  endtask
  // bounded wait for the bus reset to let go after a device reset
  task automatic wait_rel;
    int n;
    n = 0;
    while (rst_n !== 1'h1 && n < 200)
    begin
      tick(1);
      n++;
    end
    chk(n >= H && n < 200, 1'h1);
    if (n >= 200)
    begin
      summarize();
    end
  endtask
  task automatic t_power;
    chk(rst_n, 1'h0);
    chk(hoe, 1'h0);
    nrst_i = 1'h1;
    pg = 1'h1;
    wait_rel();
    chk({hoe, hn}, 2'h3);
    $display("test power done");
  endtask
  task automatic t_bus;
    go(1'h1, 32'hdead_bee0, 32'h1357_9bdf);
    fin();
    chk(addr_q, 32'hdead_bee0);
    chk(wdat_q, 32'h1357_9bdf);
    wt = 4'h3;
    go(1'h1, 32'h0000_0104, 32'hffff_fffe);
    fin();
    chk(wdat_q, 32'hffff_fffe);
    wt = 4'h2;
    rdv = 32'h8000_0001;
    go(1'h0, 32'h0000_2000, 32'h0);
    fin();
    chk(rdo, 32'h8000_0001);
    $display("test transfers done");
  endtask
  task automatic t_pas;
    wt = 4'h0;
    tick(3);
    go(1'h1, 32'h0000_0040, 32'h0f0f_0f0f);
    tick(1);
    prel = 1'h1;
    tick(1);
    prel = 1'h0;
    chk(hn, 1'h1);
    tick(1);
    chk(hn, 1'h0);
    fin();
    chk(wdat_q, 32'h0f0f_0f0f);
    $display("test passive release done");
  endtask
  task automatic t_tgt;
    tick(3);
    tga = 1'h1;
    tgdat = 32'h0000_0007;
    tgd = 1'h1;
    tick(1);
    tgd = 1'h0;
    chk(ab.ad, 32'h0000_0007);
    tick(1);
    chk({poe, par}, 2'h3);
    // as target with the ready lines released no phase may complete
    chk(tdn, 1'h0);
    tga = 1'h0;
    $display("test target parity done");
  endtask
  task automatic t_hard;
    int n;
    n = 0;
    hrst = 1'h1;
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      hrst = 1'h0;
      n += (rst_n === 1'h0);
    end
    chk(32'(n), 32'(H));
    // device reset in mid-run pulls the bus reset low with no clock edge
    nrst_i = 1'h0;
    #1;
    chk(rst_n, 1'h0);
    chk(hoe, 1'h0);
    tick(1);
    nrst_i = 1'h1;
    wait_rel();
    $display("test hard reset done");
  endtask
  initial
  begin
    tick(2);
    t_power();
    t_bus();
    t_pas();
    t_tgt();
    t_hard();
    summarize();
  end
endmodule
